// ### verilog/arr_readout.sv
// Contract
// - Results refresh only on light status read
// - Channel results as byte pairs 0x95-0x98
// - Low then high byte stays coherent
// - All latched results from one cycle
// - Result picked from 26-bit buffer
// - Top bit exceeded gives 0xFFFE
// - Analog saturation gives 0xFFFF
// - Light status shows scaled per channel
// - Gain report: ch1 7:4, ch0 3:0
// - Valid flag bit 6 after full cycle
// - Light counter overflow flag bit 4
// - Overflow limit depends on integration time
// - Flicker counter overflow flag bit 3
// - Modulator analog overflow bits 1, 0
// - Scaled flag zero means multiply
// - Modulator event flag, write one clears
`timescale 1ns/1ns
`default_nettype none
`include "arr_regs.svh"
module arr_readout (
   input wire logic clock,
   input wire logic rstn,
   // Register port from the serial interface
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Measurement engine side
   input wire logic light_measure_enable,
   input wire logic cycle_done,
   input wire logic [25:0] ch0_acc,
   input wire logic [25:0] ch1_acc,
   input wire logic [3:0] channel_zero_gain_code,
   input wire logic [3:0] channel_one_gain_code,
   input wire logic ch0_analog_sat,
   input wire logic ch1_analog_sat,
   input wire logic [3:0] result_scale_setting,
   input wire logic [4:0] result_top_bit_position,
   input wire logic [7:0] integration_time_setting,
   input wire logic [25:0] light_counter,
   input wire logic flicker_active,
   input wire logic [15:0] flicker_counter,
   input wire logic modulator_zero_analog_overflow,
   input wire logic modulator_one_analog_overflow,
   output logic modulator_event_flag
);
   // ==========================================
   // State
   typedef struct packed {
      logic [7:0] rdata;
      arr_pkg::arr_chan_t ch0;
      arr_pkg::arr_chan_t ch1;
      arr_pkg::arr_chan_t pend0;
      arr_pkg::arr_chan_t pend1;
      logic pend_ok;
      logic valid;
      logic light_sat;
      logic flick_sat;
      logic mod0_sat;
      logic mod1_sat;
      logic mod_event;
      logic enable_d;
   } arr_state_t;

   arr_state_t st_r;
   arr_state_t st_nxt;

   logic [15:0] res0;
   logic [15:0] res1;
   logic sc0_n;
   logic sc1_n;
   logic top0;
   logic top1;
   logic [25:0] light_limit;
   logic [30:0] time_limit;

   // ==========================================
   // Formatting of each channel
   arr_chan_format u_fmt0 (
      .acc(ch0_acc),
      .analog_sat(ch0_analog_sat),
      .scale_setting(result_scale_setting),
      .top_bit_pos(result_top_bit_position),
      .result(res0),
      .scaled_n(sc0_n),
      .top_exceeded(top0)
   );
   arr_chan_format u_fmt1 (
      .acc(ch1_acc),
      .analog_sat(ch1_analog_sat),
      .scale_setting(result_scale_setting),
      .top_bit_pos(result_top_bit_position),
      .result(res1),
      .scaled_n(sc1_n),
      .top_exceeded(top1)
   );

   // ==========================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      // Counter ceiling: format limit or integration time, the smaller
      light_limit = 26'h3FFFFFF >> (5'd25 - result_top_bit_position);
      time_limit = {13'h0, integration_time_setting, 10'h3FF};
      if (time_limit[25:0] < light_limit) begin
         light_limit = time_limit[25:0];
      end
      st_nxt.enable_d = light_measure_enable;
      // Snapshot both channels together at the cycle end
      if (cycle_done) begin
         st_nxt.pend0 = '{value: res0, gain: channel_zero_gain_code,
                          scaled_n: sc0_n};
         st_nxt.pend1 = '{value: res1, gain: channel_one_gain_code,
                          scaled_n: sc1_n};
         st_nxt.pend_ok = 1'b1;
      end
      if (reg_rd && reg_addr == `ARR_OFS_LIGHT_STATUS) begin
         // Latch only here, so byte pairs stay coherent
         if (st_r.pend_ok) begin
            st_nxt.ch0 = st_r.pend0;
            st_nxt.ch1 = st_r.pend1;
         end
         st_nxt.valid = 1'b0;
      end
      if (light_measure_enable && !st_r.enable_d) begin
         st_nxt.valid = 1'b0;
      end
      // Set wins over the read-clear
      if (cycle_done && light_measure_enable) begin
         st_nxt.valid = 1'b1;
      end
      // Clear first, so a saturation in the same cycle wins
      if (reg_wr && reg_addr == `ARR_OFS_MAIN_STATUS &&
          reg_wdata[`ARR_BIT_MOD_EVENT]) begin
         st_nxt.light_sat = 1'b0;
         st_nxt.flick_sat = 1'b0;
         st_nxt.mod0_sat = 1'b0;
         st_nxt.mod1_sat = 1'b0;
      end
      if (light_counter >= light_limit || top0 || top1) begin
         st_nxt.light_sat = 1'b1;
      end
      if (flicker_active && flicker_counter == 16'hFFFF) begin
         st_nxt.flick_sat = 1'b1;
      end
      if (modulator_zero_analog_overflow) begin
         st_nxt.mod0_sat = 1'b1;
      end
      if (modulator_one_analog_overflow) begin
         st_nxt.mod1_sat = 1'b1;
      end
      if (reg_wr && reg_addr == `ARR_OFS_MAIN_STATUS &&
          reg_wdata[`ARR_BIT_MOD_EVENT]) begin
         // Write one clears the event; flags were cleared above
         st_nxt.mod_event = 1'b0;
      end
      // New counter or modulator saturation beats a simultaneous clear; top bit exceeded does not set the event
      if (modulator_zero_analog_overflow || modulator_one_analog_overflow
          || (flicker_active && flicker_counter == 16'hFFFF)
          || light_counter >= light_limit) begin
         st_nxt.mod_event = 1'b1;
      end
      // Read data decode
      if (reg_addr == `ARR_OFS_CH0_LOW) begin
         st_nxt.rdata = st_r.ch0.value[7:0];
      end else if (reg_addr == `ARR_OFS_CH0_HIGH) begin
         st_nxt.rdata = st_r.ch0.value[15:8];
      end else if (reg_addr == `ARR_OFS_CH1_LOW) begin
         st_nxt.rdata = st_r.ch1.value[7:0];
      end else if (reg_addr == `ARR_OFS_CH1_HIGH) begin
         st_nxt.rdata = st_r.ch1.value[15:8];
      end else if (reg_addr == `ARR_OFS_GAIN) begin
         st_nxt.rdata = {st_r.ch1.gain, st_r.ch0.gain};
      end else if (reg_addr == `ARR_OFS_LIGHT_STATUS) begin
         st_nxt.rdata = `ARR_RESET_BYTE;
         // Shows the pair that this read is about to latch
         st_nxt.rdata[`ARR_BIT_CH0_SCALED] = st_r.pend_ok ?
            st_r.pend0.scaled_n : st_r.ch0.scaled_n;
         st_nxt.rdata[`ARR_BIT_CH1_SCALED] = st_r.pend_ok ?
            st_r.pend1.scaled_n : st_r.ch1.scaled_n;
      end else if (reg_addr == `ARR_OFS_SAT_FLAGS) begin
         st_nxt.rdata = `ARR_RESET_BYTE;
         st_nxt.rdata[`ARR_BIT_VALID] = st_r.valid;
         st_nxt.rdata[`ARR_BIT_LIGHT_SAT] = st_r.light_sat;
         st_nxt.rdata[`ARR_BIT_FLICK_SAT] = st_r.flick_sat;
         st_nxt.rdata[`ARR_BIT_MOD1_SAT] = st_r.mod1_sat;
         st_nxt.rdata[`ARR_BIT_MOD0_SAT] = st_r.mod0_sat;
      end else if (reg_addr == `ARR_OFS_MAIN_STATUS) begin
         st_nxt.rdata = `ARR_RESET_BYTE;
         st_nxt.rdata[`ARR_BIT_MOD_EVENT] = st_r.mod_event;
      end else begin
         st_nxt.rdata = `ARR_RESET_BYTE;
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge clock) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;
   assign modulator_event_flag = st_r.mod_event;
endmodule : arr_readout
`default_nettype wire

// ### verilog/arr_regs.svh
`ifndef ARR_REGS_SVH
`define ARR_REGS_SVH
// Register offsets
`define ARR_OFS_LIGHT_STATUS 8'h94
`define ARR_OFS_CH0_LOW 8'h95
`define ARR_OFS_CH0_HIGH 8'h96
`define ARR_OFS_CH1_LOW 8'h97
`define ARR_OFS_CH1_HIGH 8'h98
`define ARR_OFS_GAIN 8'h9B
`define ARR_OFS_MAIN_STATUS 8'h93
`define ARR_OFS_SAT_FLAGS 8'h9D
// Field positions
`define ARR_BIT_MOD_EVENT 7
`define ARR_BIT_VALID 6
`define ARR_BIT_LIGHT_SAT 4
`define ARR_BIT_FLICK_SAT 3
`define ARR_BIT_MOD1_SAT 1
`define ARR_BIT_MOD0_SAT 0
`define ARR_BIT_CH0_SCALED 2
`define ARR_BIT_CH1_SCALED 1
// Fixed result codes and reset value
`define ARR_CODE_TOP_EXCEEDED 16'hFFFE
`define ARR_CODE_ANALOG_SAT 16'hFFFF
`define ARR_RESET_BYTE 8'h00
`define ARR_ACC_W 26
`define ARR_RES_W 16
`endif

// ### verilog/arr_pkg.sv
package arr_pkg;
   typedef struct packed {
      logic [15:0] value;
      logic [3:0] gain;
      logic scaled_n;
   } arr_chan_t;
endpackage : arr_pkg

// ### verilog/arr_chan_format.sv
`timescale 1ns/1ns
`default_nettype none
`include "arr_regs.svh"
// Picks 16 result bits out of the accumulation buffer.
module arr_chan_format (
   input wire logic [25:0] acc,
   input wire logic analog_sat,
   input wire logic [3:0] scale_setting,
   input wire logic [4:0] top_bit_pos,
   output logic [15:0] result,
   output logic scaled_n,
   output logic top_exceeded
);
   logic [25:0] shifted;
   logic [25:0] limit_mask;
   logic [4:0] shift;
   always_comb begin
      // With a nonzero scale setting the window ends at the top bit (bit 15 at least), else it is bits 15:0; scaling drops low bits
      shift = (top_bit_pos > 5'd15) ? 5'(top_bit_pos - 5'd15) : 5'd0;
      if (scale_setting == 4'h0) begin
         shift = 5'd0;
      end
      limit_mask = ~((26'h3FFFFFF >> (5'd25 - top_bit_pos)));
      if (top_bit_pos > 5'd25) begin
         limit_mask = 26'h0;
      end
      top_exceeded = |(acc & limit_mask);
      shifted = acc >> shift;
      scaled_n = (shift == 5'd0);
      if (analog_sat) begin
         result = `ARR_CODE_ANALOG_SAT;
      end else if (top_exceeded) begin
         result = `ARR_CODE_TOP_EXCEEDED;
      end else begin
         result = shifted[15:0];
      end
   end
endmodule : arr_chan_format
`default_nettype wire

// ### tb/arr_readout_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ========
// Checker
module arr_chk (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic cycle_done,
   input wire logic modulator_zero_analog_overflow,
   input wire logic modulator_one_analog_overflow,
   input wire logic modulator_event_flag
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence s_stat_rd;
      reg_rd && reg_addr == 8'h94;
   endsequence
   sequence s_idle_lo;
      (reg_addr == 8'h95 && !reg_rd)[*3];
   endsequence
   unmapped_read_a: assert property (
      reg_addr == 8'h99 |=> reg_rdata == 8'h00) else $error("unmapped");
   valid_clear_a: assert property (
      !cycle_done throughout (s_stat_rd ##[1:2] reg_addr == 8'h9D)
      |=> !reg_rdata[6]) else $error("valid kept");
   sat_reserved_a: assert property (
      reg_addr == 8'h9D |=> (reg_rdata & 8'hA4) == 8'h00)
      else $error("reserved bits");
   status_bits_a: assert property (
      reg_addr == 8'h94 |=> (reg_rdata & 8'hF9) == 8'h00)
      else $error("status bits");
   data_hold_a: assert property (
      s_idle_lo |=> $stable(reg_rdata)) else $error("result moved");
   mod0_flag_a: assert property (
      (reg_addr == 8'h9D && modulator_zero_analog_overflow)[*3]
      |=> reg_rdata[0]) else $error("mod0 flag");
   mod1_flag_a: assert property (
      (reg_addr == 8'h9D && modulator_one_analog_overflow)[*3]
      |=> reg_rdata[1]) else $error("mod1 flag");
   event_set_a: assert property (
      modulator_zero_analog_overflow || modulator_one_analog_overflow
      |-> ##[1:2] modulator_event_flag) else $error("event late");
   event_hold_a: assert property (
      modulator_event_flag && !(reg_wr && reg_addr == 8'h93 && reg_wdata[7])
      |=> modulator_event_flag) else $error("event lost");
endmodule : arr_chk
bind arr_readout arr_chk u_chk (.clock, .rstn, .reg_addr, .reg_rd, .reg_wr,
   .reg_wdata, .reg_rdata, .cycle_done, .modulator_zero_analog_overflow,
   .modulator_one_analog_overflow, .modulator_event_flag);
`default_nettype wire

// ### tb/arr_host.sv
`timescale 1ns/1ns
`default_nettype none
// ========
// Host on the register port
module arr_host (
   input wire logic clock,
   output logic [7:0] reg_addr,
   output logic reg_rd,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial begin
      {reg_addr, reg_wdata} = 16'h0000;
      {reg_rd, reg_wr} = 2'h0;
   end
   // Address stays put after a read, as a level, until the next access
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
endmodule : arr_host
`default_nettype wire

// ### tb/test_ambient_result_readout.sv
`timescale 1ns/1ns
`default_nettype none
// ========
// Bench
module test_ambient_result_readout;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, it, d;
   logic reg_rd, reg_wr, en, done, s0, s1, fa, m0, m1, ev;
   logic [25:0] a0, a1, lc;
   logic [3:0] g0, g1, sc;
   logic [4:0] tp;
   logic [15:0] fc;
   int err_total = 0;
   int comparisons = 0;
   always #50 clock = ~clock;
   arr_host host (.clock, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
      .reg_rdata);
   arr_readout dut (.clock, .rstn, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
      .reg_rdata, .light_measure_enable(en), .cycle_done(done),
      .ch0_acc(a0), .ch1_acc(a1), .channel_zero_gain_code(g0),
      .channel_one_gain_code(g1), .ch0_analog_sat(s0), .ch1_analog_sat(s1),
      .result_scale_setting(sc), .result_top_bit_position(tp),
      .integration_time_setting(it), .light_counter(lc),
      .flicker_active(fa), .flicker_counter(fc),
      .modulator_zero_analog_overflow(m0),
      .modulator_one_analog_overflow(m1), .modulator_event_flag(ev));
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task rdc(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, d);
      chk($sformatf("reg %h", a), e, d);
   endtask : rdc
   task cyc;
      @(posedge clock);
      done <= 1'b1;
      @(posedge clock);
      done <= 1'b0;
      repeat (2) @(posedge clock);
   endtask : cyc
   task t_reset;
      for (int i = 0; i < 7; i++) begin
         rdc(i == 6 ? 8'h99 : (i == 5 ? 8'h9D : (i == 4 ? 8'h9B :
            8'h95 + 8'(i))), 8'h00);
      end
   endtask : t_reset
   task t_scale;
      @(posedge clock);
      sc <= 4'h1;
      tp <= 5'd17;
      a0 <= 26'h0012345;
      a1 <= 26'h0040000;
      cyc;
      rdc(8'h94, 8'h00);
      rdc(8'h95, 8'hD1);
      rdc(8'h96, 8'h48);
      rdc(8'h97, 8'hFE);
      rdc(8'h98, 8'hFF);
   endtask : t_scale
   task t_result;
      @(posedge clock);
      en <= 1'b1;
      a0 <= 26'h0001234;
      a1 <= 26'h000ABCD;
      g0 <= 4'h3;
      g1 <= 4'hA;
      cyc;
      rdc(8'h9D, 8'h40);
      rdc(8'h94, 8'h06);
      rdc(8'h9D, 8'h00);
      rdc(8'h95, 8'h34);
      rdc(8'h96, 8'h12);
      rdc(8'h97, 8'hCD);
      rdc(8'h98, 8'hAB);
      rdc(8'h9B, 8'hA3);
   endtask : t_result
   task t_hold;
      a0 <= 26'h0010000;
      a1 <= 26'h0000055;
      s1 <= 1'b1;
      g0 <= 4'h5;
      g1 <= 4'h6;
      cyc;
      rdc(8'h98, 8'hAB);
      rdc(8'h9B, 8'hA3);
      rdc(8'h95, 8'h34);
      repeat (3) @(posedge clock);
      host.rd(8'h94, d);
      s1 <= 1'b0;
      rdc(8'h95, 8'hFE);
      rdc(8'h96, 8'hFF);
      rdc(8'h97, 8'hFF);
      rdc(8'h98, 8'hFF);
      rdc(8'h9B, 8'h65);
   endtask : t_hold
   task t_sat;
      lc <= 26'h0000400;
      fa <= 1'b1;
      fc <= 16'hFFFF;
      {m0, m1} <= 2'h3;
      cyc;
      host.rd(8'h9D, d);
      repeat (2) @(posedge clock);
      chk("sat flags", 8'h1B, d & 8'h1B);
      chk("event", 8'h01, {7'h00, ev});
      {lc, fa, fc, m0, m1} <= '0;
      a0 <= 26'h0000000;
      host.wr(8'h93, 8'h80);
      repeat (2) @(posedge clock);
      host.rd(8'h9D, d);
      chk("flags cleared", 8'h00, d & 8'h1B);
      chk("event cleared", 8'h00, {7'h00, ev});
   endtask : t_sat
   task end_sim;
      $display("Comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      {en, done, s0, s1, fa, m0, m1} = '0;
      {a0, a1, lc, fc} = '0;
      {g0, g1, it} = '0;
      sc = 4'h0;
      tp = 5'h0F;
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      t_reset;
      t_result;
      t_hold;
      t_sat;
      t_scale;
      end_sim;
   end
   initial begin
      #(100 * 3000);
      err_total++;
      end_sim;
   end
endmodule : test_ambient_result_readout
`default_nettype wire
